// >>> hdl/ufm_uart.sv
// Purpose: Four-mode serial port with multiprocessor address recognition.
// Assumes: Software strobes are one-cycle pulses on clk; timer overflows arrive as pulses.
// Notes:   Control bits are plain ports; the shift engine is shared by all transmit work
//          and by synchronous reception, since the synchronous mode is half duplex.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Synchronous mode shifts data on serial_in_pin and drives shift clock on serial_out_pin.
// - Synchronous write sends eight bits LSB first; transmit-done at end of eighth.
// - Synchronous receive starts when enabled and receive-done clear; flag one cycle after bit eight.
// - Synchronous bit time is twelve clocks; serial_in_pin is only pulled low.
// - 8-bit asynchronous frame: start, eight data LSB first, stop.
// - 8-bit mode loads byte and stop only if receive-done clear and, with multiprocessor enable set, stop valid.
// - Asynchronous write starts sending; transmit-done set as the stop bit begins.
// - Asynchronous receiver accepts a frame any time while receive enable is set.
// - Interrupt request follows either done flag when enabled.
// - One baud pulse per selected timer overflow, per second overflow for the 8-bit timer without double bit; separate transmit and receive selects.
// - 8-bit timer gives overflow/32, or overflow/16 with double bit; bit resets low.
// - 16-bit timers give overflow/16.
// - 9-bit frames: start, eight data LSB first, ninth from control bit, stop.
// - 9-bit receive stores ninth bit; loads only if flag clear and, with multiprocessor enable set, address rules pass.
// - Fixed 9-bit mode runs at clk/64, or clk/32 with double bit.
// - Variable 9-bit mode uses 9-bit framing with timer baud generation.
// - Address match compares only bits where the mask is one.
// - Broadcast address is address OR mask; its zero bits are ignored.
// - Done flags stay set until software clears them.
// - Asynchronous overrun on unread byte replaced; framing error on low stop bit.
// - Writing data while a transfer runs sets the collision flag.
module ufm_uart (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire ufm_pkg::ufm_mode_e mode,
    input  wire logic               receive_enable_bit,
    input  wire logic               multiproc_enable,
    input  wire logic               baud_double_bit,
    input  wire logic               transmit_ninth_bit,
    input  wire logic               tx_baud_select_hi,
    input  wire logic               tx_baud_select_lo,
    input  wire logic               rx_baud_select_hi,
    input  wire logic               rx_baud_select_lo,
    input  wire logic [7:0]         slave_address_reg,
    input  wire logic [7:0]         slave_address_mask,
    input  wire logic               irq_enable,
    input  wire logic [3:0]         timer_ovf,
    input  wire logic               data_write,
    input  wire logic [7:0]         data_write_byte,
    input  wire logic               data_read,
    input  wire logic               clear_tx_done,
    input  wire logic               clear_rx_done,
    input  wire logic               clear_overrun,
    input  wire logic               clear_framing,
    input  wire logic               clear_collision,
    input  wire logic               serial_in_pin,
    output logic                    serial_in_pin_out,
    output logic                    serial_in_pin_oe,
    output logic                    serial_out_pin,
    output logic [7:0]              serial_data_buffer,
    output logic                    received_ninth_bit,
    output logic                    transmit_done_flag,
    output logic                    receive_done_flag,
    output logic                    receive_overrun_flag,
    output logic                    framing_error_flag,
    output logic                    transmit_collision_flag,
    output logic                    irq
);
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_ATX  = 2'b01,
        SH_M0TX = 2'b10,
        SH_M0RX = 2'b11
    } ufm_shift_e;

    ufm_shift_e sh_state;
    logic [3:0] phase;
    logic [3:0] bits;
    logic [10:0] shreg;
    logic       rx_meta;
    logic       rx_s;
    logic       m0_fin;
    logic       unread;
    logic       tx_tick;
    logic       rx_tick;
    logic       rx_done;
    logic [7:0] rx_data;
    logic       rx_ninth;
    logic       rx_stop;

    wire is_sync   = (mode == ufm_pkg::MODE_SYNC);
    wire is_nine   = mode[1];
    wire idle      = (sh_state == SH_IDLE);
    wire in_sync   = (sh_state == SH_M0TX) || (sh_state == SH_M0RX);
    // In the synchronous mode the engine ticks every clock and counts twelve per bit.
    wire sh_tick   = is_sync || tx_tick;
    wire [3:0] last = in_sync ? ufm_pkg::M0_LAST : ufm_pkg::OVS_LAST;
    wire phase_end = sh_tick && (phase == last) && !idle;
    wire m0_sample = (sh_state == SH_M0RX) && (phase == ufm_pkg::M0_HALF);
    wire start_tx  = data_write && idle;
    wire collide   = data_write && !idle;
    wire m0rx_go   = is_sync && receive_enable_bit && !receive_done_flag && idle && !data_write && !m0_fin;

    // Transmit-done moment differs: start of stop bit when asynchronous, end of bit eight when not.
    wire ti_async  = (sh_state == SH_ATX) && phase_end && (bits == ufm_pkg::BITS_STOP);
    wire ti_sync   = (sh_state == SH_M0TX) && phase_end && (bits == 4'h1);
    wire set_ti    = ti_async || ti_sync;

    // Masked and broadcast address checks.
    wire [7:0] bcast     = slave_address_reg | slave_address_mask;
    wire       hit_mask  = (((rx_data ^ slave_address_reg) & slave_address_mask) == 8'h00);
    wire       hit_bcast = ((rx_data & bcast) == bcast);
    wire       addr_hit  = hit_mask || hit_bcast;
    // Acceptance for asynchronous frames.
    wire       mp_ok     = is_nine ? (rx_ninth && addr_hit) : rx_stop;
    wire       rx_accept = rx_done && !receive_done_flag && (!multiproc_enable || mp_ok);
    wire       rx_load   = rx_accept || m0_fin;
    wire       set_ri    = rx_load;

    wire [10:0] tx_frame = is_sync ? {3'b111, data_write_byte} :
                           is_nine ? {1'b1, transmit_ninth_bit, data_write_byte, 1'b0} :
                                     {2'b11, data_write_byte, 1'b0};
    wire [3:0]  tx_bits  = is_sync ? ufm_pkg::BITS_SYNC : is_nine ? ufm_pkg::BITS_9N1 : ufm_pkg::BITS_8N1;

    // Shift clock is low for the first half of each bit, high for the second.
    wire next_clk_pin = !(in_sync && (phase < ufm_pkg::M0_HALF));
    wire next_out_pin = is_sync ? next_clk_pin : ((sh_state == SH_ATX) ? shreg[0] : 1'b1);
    wire next_in_oe   = (sh_state == SH_M0TX) && !shreg[0];

    ufm_baud u_baud (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .mode            (mode),
        .baud_double_bit (baud_double_bit),
        .tx_sel          ({tx_baud_select_hi, tx_baud_select_lo}),
        .rx_sel          ({rx_baud_select_hi, rx_baud_select_lo}),
        .timer_ovf       (timer_ovf),
        .tx_tick         (tx_tick),
        .rx_tick         (rx_tick)
    );

    ufm_rx u_rx (
        .clk    (clk),
        .sys_rst(sys_rst),
        .enable (receive_enable_bit && !is_sync),
        .nine   (is_nine),
        .tick   (rx_tick),
        .rxd    (rx_s),
        .done   (rx_done),
        .data   (rx_data),
        .ninth  (rx_ninth),
        .stop   (rx_stop)
    );

    // The pin comes from outside; two flops before anything reads it.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_meta <= 1'b1;
            rx_s    <= 1'b1;
        end else begin
            rx_meta <= serial_in_pin;
            rx_s    <= rx_meta;
        end
    end

    // Shift engine for all transmit frames and synchronous reception.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sh_state <= SH_IDLE;
            phase    <= 4'h0;
            bits     <= 4'h0;
            shreg    <= 11'h7ff;
            m0_fin   <= 1'b0;
        end else begin
            m0_fin <= 1'b0;
            if (idle) begin
                phase <= 4'h0;
                if (start_tx) begin
                    shreg    <= tx_frame;
                    bits     <= tx_bits;
                    sh_state <= is_sync ? SH_M0TX : SH_ATX;
                end else if (m0rx_go) begin
                    bits     <= ufm_pkg::BITS_SYNC;
                    sh_state <= SH_M0RX;
                end
            end else if (sh_tick) begin
                phase <= (phase == last) ? 4'h0 : phase + 4'h1;
                // Received bits enter at the top, so the first lands in bit 0.
                if (m0_sample) begin
                    shreg <= {3'b111, rx_s, shreg[7:1]};
                    bits  <= bits - 4'h1;
                    if (bits == 4'h1) begin
                        m0_fin   <= 1'b1;
                        sh_state <= SH_IDLE;
                    end
                end else if (phase_end && (sh_state != SH_M0RX)) begin
                    shreg <= {1'b1, shreg[10:1]};
                    bits  <= bits - 4'h1;
                    if (bits == 4'h1) begin
                        sh_state <= SH_IDLE;
                    end
                end
            end
        end
    end

    // Pins; the open-drain line is only ever pulled low.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serial_out_pin    <= 1'b1;
            serial_in_pin_out <= 1'b0;
            serial_in_pin_oe  <= 1'b0;
        end else begin
            serial_out_pin    <= next_out_pin;
            serial_in_pin_out <= 1'b0;
            serial_in_pin_oe  <= next_in_oe;
        end
    end

    // Receive buffer loads only on accepted frames.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serial_data_buffer <= 8'h00;
            received_ninth_bit <= 1'b0;
        end else if (m0_fin) begin
            serial_data_buffer <= shreg[7:0];
        end else if (rx_accept) begin
            serial_data_buffer <= rx_data;
            received_ninth_bit <= is_nine ? rx_ninth : rx_stop;
        end
    end

    // Flags: hardware set wins over a clear in the same cycle; nothing else clears them.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            transmit_done_flag      <= 1'b0;
            receive_done_flag       <= 1'b0;
            receive_overrun_flag    <= 1'b0;
            framing_error_flag      <= 1'b0;
            transmit_collision_flag <= 1'b0;
            unread                  <= 1'b0;
            irq                     <= 1'b0;
        end else begin
            transmit_done_flag      <= set_ti || (transmit_done_flag && !clear_tx_done);
            receive_done_flag       <= set_ri || (receive_done_flag && !clear_rx_done);
            // Overrun: an accepted byte replaces one software never read.
            receive_overrun_flag    <= (rx_accept && unread && !data_read) ||
                                       (receive_overrun_flag && !clear_overrun);
            framing_error_flag      <= (rx_done && !rx_stop) || (framing_error_flag && !clear_framing);
            transmit_collision_flag <= collide || (transmit_collision_flag && !clear_collision);
            unread                  <= rx_load || (unread && !data_read);
            // Interrupt follows the flags while enabled.
            irq                     <= irq_enable && (transmit_done_flag || receive_done_flag);
        end
    end

    collide_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        data_write && !idle && !phase_end && !m0_sample |=> transmit_collision_flag && $stable(shreg))
        else $error("collision not flagged or transfer disturbed");

    async_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        data_write && idle && !is_sync |=> sh_state == SH_ATX && !shreg[0])
        else $error("asynchronous write did not start a frame with a start bit");

    ti_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        ti_async |=> transmit_done_flag && shreg[0])
        else $error("transmit done not set at stop bit");

    m0_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_sync && phase == 4'h0 && $past(phase) == 4'hb |-> ##6 (phase == 4'h6 || idle))
        else $error("synchronous bit time wrong");

    m0_done_a: assert property (@(posedge clk) disable iff (sys_rst)
        m0_sample && bits == 4'h1 |=> ##1 receive_done_flag && !in_sync)
        else $error("synchronous receive done not set one cycle after last bit");

    odrain_a: assert property (@(posedge clk) disable iff (sys_rst)
        serial_in_pin_oe |-> !serial_in_pin_out && $past(sh_state) == SH_M0TX)
        else $error("open-drain pin driven outside synchronous transmit");

    ri_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        receive_done_flag && !clear_rx_done |=> receive_done_flag)
        else $error("receive done cleared without software");

    irq_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
        irq_enable && (transmit_done_flag || receive_done_flag) |=> irq)
        else $error("interrupt request missing");

    full_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        rx_done && receive_done_flag |=> $stable(serial_data_buffer))
        else $error("buffer loaded while receive done set");

    frame_err_a: assert property (@(posedge clk) disable iff (sys_rst)
        rx_done && !rx_stop |=> framing_error_flag)
        else $error("framing error not flagged");

endmodule : ufm_uart
`default_nettype wire

// >>> inc/ufm_pkg.sv
// Purpose: Shared constants and types for the four-mode serial port.
// Assumes: One 50 MHz system clock; timer overflow pulses arrive on that clock.
// Notes:   Divider counts are terminal values, one less than the divide ratio; bit counts are not.
package ufm_pkg;

    typedef enum logic [1:0] {
        MODE_SYNC   = 2'b00,
        MODE_ASYNC8 = 2'b01,
        MODE_FIXED9 = 2'b10,
        MODE_VAR9   = 2'b11
    } ufm_mode_e;

    // Baud source select codes, one field per direction.
    localparam logic [1:0] SEL_T8  = 2'h0;
    localparam logic [1:0] SEL_T16A = 2'h1;
    localparam logic [1:0] SEL_T16B = 2'h2;
    localparam logic [1:0] SEL_T16C = 2'h3;

    // Synchronous mode: one bit every twelve system clocks.
    localparam logic [3:0] M0_LAST   = 4'hb;
    localparam logic [3:0] M0_HALF   = 4'h6;
    // Asynchronous modes: sixteen baud ticks per bit.
    localparam logic [3:0] OVS_LAST  = 4'hf;
    localparam logic [3:0] OVS_MID   = 4'h7;
    // Fixed-rate mode: a tick every 4 clocks (clk/64) or every 2 (clk/32).
    localparam logic [1:0] FIX_SLOW  = 2'h3;
    localparam logic [1:0] FIX_FAST  = 2'h1;

    // Bits per frame as shifted by the transmitter; BITS_STOP is the count during the last bit before stop.
    localparam logic [3:0] BITS_SYNC = 4'h8;
    localparam logic [3:0] BITS_8N1  = 4'ha;
    localparam logic [3:0] BITS_9N1  = 4'hb;
    localparam logic [3:0] BITS_STOP = 4'h2;
    // Bits after the start bit as sampled by the receiver.
    localparam logic [3:0] RX_BITS8  = 4'h9;
    localparam logic [3:0] RX_BITS9  = 4'ha;

endpackage : ufm_pkg

// >>> hdl/ufm_baud.sv
// Purpose: Baud tick generation for both directions of the serial port.
// Assumes: Overflow inputs are one-cycle pulses from timers on clk.
// Notes:   Ticks run at sixteen per bit; the 8-bit timer path halves its rate unless doubled.
`timescale 1ns/10ps
`default_nettype none
module ufm_baud (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire ufm_pkg::ufm_mode_e mode,
    input  wire logic               baud_double_bit,
    input  wire logic [1:0]         tx_sel,
    input  wire logic [1:0]         rx_sel,
    input  wire logic [3:0]         timer_ovf,
    output logic                    tx_tick,
    output logic                    rx_tick
);
    function automatic logic pick(input logic [1:0] sel, input logic [3:0] ovf);
        return ovf[sel];
    endfunction : pick

    logic [1:0] half;
    logic [1:0] pre;
    wire  [1:0] sel_ovf  = {pick(rx_sel, timer_ovf), pick(tx_sel, timer_ovf)};
    wire  [1:0] is_t8    = {rx_sel == ufm_pkg::SEL_T8, tx_sel == ufm_pkg::SEL_T8};
    wire        fix_tick = (pre == 2'h0);
    logic [1:0] var_tick;

    genvar d;
    generate
        for (d = 0; d < 2; d++) begin : g_dir
            // The 8-bit timer gives 1/32 of its overflow rate by default, 1/16 when doubled.
            // The 16-bit timers always give 1/16, one tick per overflow.
            assign var_tick[d] = sel_ovf[d] && (!is_t8[d] || baud_double_bit || half[d]);
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    half[d] <= 1'b0;
                end else if (sel_ovf[d] && is_t8[d]) begin
                    half[d] <= ~half[d];
                end
            end
        end
    endgenerate

    // Fixed-rate mode ticks at clk/4 or clk/2, giving clk/64 or clk/32 per bit.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre <= ufm_pkg::FIX_SLOW;
        end else if (fix_tick) begin
            pre <= baud_double_bit ? ufm_pkg::FIX_FAST : ufm_pkg::FIX_SLOW;
        end else begin
            pre <= pre - 2'h1;
        end
    end

    // The variable 9-bit mode shares the timer path of the 8-bit mode.
    assign tx_tick = (mode == ufm_pkg::MODE_FIXED9) ? fix_tick : var_tick[0];
    assign rx_tick = (mode == ufm_pkg::MODE_FIXED9) ? fix_tick : var_tick[1];

endmodule : ufm_baud
`default_nettype wire

// >>> hdl/ufm_rx.sv
// Purpose: Asynchronous frame receiver with sixteen-times oversampling.
// Assumes: rxd is already synchronised to clk.
// Notes:   A start bit still high at mid-bit is taken as noise and dropped.
`timescale 1ns/10ps
`default_nettype none
module ufm_rx (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       enable,
    input  wire logic       nine,
    input  wire logic       tick,
    input  wire logic       rxd,
    output logic            done,
    output logic [7:0]      data,
    output logic            ninth,
    output logic            stop
);
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b10
    } ufm_rx_state_e;

    ufm_rx_state_e state;
    logic          prev;
    logic [3:0]    cnt;
    logic [3:0]    left;
    logic [9:0]    sh;

    wire fall   = prev && !rxd;
    wire mid    = tick && (cnt == ufm_pkg::OVS_MID);
    wire bitend = tick && (cnt == ufm_pkg::OVS_LAST);

    // Frames are caught whenever enabled; start is the falling edge.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= RX_IDLE;
            prev  <= 1'b1;
            cnt   <= 4'h0;
            left  <= 4'h0;
            sh    <= 10'h000;
            done  <= 1'b0;
        end else begin
            prev <= rxd;
            done <= 1'b0;
            if (tick) begin
                cnt <= cnt + 4'h1;
            end
            unique case (state)
                RX_IDLE: begin
                    cnt <= 4'h0;
                    if (enable && fall) begin
                        state <= RX_START;
                    end
                end
                RX_START: begin
                    if (mid) begin
                        cnt   <= 4'h0;
                        left  <= nine ? ufm_pkg::RX_BITS9 : ufm_pkg::RX_BITS8;
                        state <= rxd ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: begin
                    // Sample each bit at its centre, sixteen ticks apart.
                    if (bitend) begin
                        sh   <= {rxd, sh[9:1]};
                        left <= left - 4'h1;
                        if (left == 4'h1) begin
                            done  <= 1'b1;
                            state <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Bits enter at the top, so a shorter 8-bit frame leaves its byte one place higher.
    // The stop bit always ends in the top bit.
    assign data  = nine ? sh[7:0] : sh[8:1];
    assign ninth = sh[8];
    assign stop  = sh[9];

endmodule : ufm_rx
`default_nettype wire

// >>> bench/ufm_peer.sv
// Purpose: Remote serial peer driving the receive line.
// Assumes: Bit time is given in system clocks.
// Notes:   The line idles high, as its pull-up would leave it.
`timescale 1ns/10ps
`default_nettype none
module ufm_peer (
    input  wire logic clk,
    output logic      line
);
    initial line = 1'b1;
    // Start bit, then f[n-1:0] LSB first; the caller supplies the stop bit.
    task automatic send(input logic [9:0] f, input int n, input int bc);
        int i;
        for (i = 0; i <= n; i++) begin
            line <= (i == 0) ? 1'b0 : f[i-1];
            repeat (bc) @(posedge clk);
        end
        line <= 1'b1;
    endtask : send
endmodule : ufm_peer
`default_nettype wire

// >>> bench/ufm_uart_test.sv
// Purpose: Self-checking bench for the four-mode serial port.
// Assumes: Timer overflows 0 and 1 pulse every second clock; overflows 2 and 3 stay low.
// Notes:   Line and flag samples are taken one nanosecond after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module ufm_uart_test;
    ufm_pkg::ufm_mode_e mode;
    logic clk, sys_rst, receive_enable_bit, multiproc_enable, baud_double_bit, transmit_ninth_bit, irq_enable;
    logic tx_baud_select_hi, tx_baud_select_lo, rx_baud_select_hi, rx_baud_select_lo, data_write, data_read;
    logic clear_tx_done, clear_rx_done, clear_overrun, clear_framing, clear_collision;
    logic [7:0] slave_address_reg, slave_address_mask, data_write_byte, serial_data_buffer;
    logic [3:0] timer_ovf = 4'h0;
    logic serial_in_pin_out, serial_in_pin_oe, serial_out_pin, received_ninth_bit, irq, transmit_done_flag;
    logic receive_done_flag, receive_overrun_flag, framing_error_flag, transmit_collision_flag;
    wire  serial_in_pin, peer_line;
    int   errors = 0;
    int   check_count = 0;

    ufm_uart DUT (.*);
    ufm_peer peer (.clk(clk), .line(peer_line));
    // Open drain: the port can only pull the shared line low.
    assign serial_in_pin = peer_line & ~serial_in_pin_oe;

    initial clk = 1'b0;
    always #10 clk = ~clk;
    always @(posedge clk) timer_ovf <= {2'b00, ~timer_ovf[0], ~timer_ovf[0]};

    task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic clr(input logic [5:0] c);
        {clear_tx_done, clear_rx_done, clear_overrun, clear_framing, clear_collision, data_read} <= c;
        @(posedge clk);
        {clear_tx_done, clear_rx_done, clear_overrun, clear_framing, clear_collision, data_read} <= 6'h00;
    endtask : clr

    // A second write lands mid-frame: it must be refused and flagged.
    task automatic txc(input ufm_pkg::ufm_mode_e m, input logic d, input logic [1:0] s, input int n, input int bc,
                       input logic [7:0] b, input logic nb);
        logic [10:0] v;
        logic [10:0] t;
        int          i;
        v = '0;
        t = '0;
        @(posedge clk);
        clr(6'h22);
        mode <= m;
        baud_double_bit <= d;
        {tx_baud_select_hi, tx_baud_select_lo} <= s;
        transmit_ninth_bit <= nb;
        data_write_byte <= b;
        @(posedge clk);
        data_write <= 1'b1;
        @(posedge clk);
        data_write <= 1'b0;
        data_write_byte <= ~b;
        @(posedge clk);
        data_write <= 1'b1;
        @(posedge clk);
        data_write <= 1'b0;
        repeat (bc / 2) @(posedge clk);
        for (i = 0; i < n; i++) begin
            #1;
            v[i] = serial_out_pin;
            t[i] = transmit_done_flag;
            repeat (bc) @(posedge clk);
        end
        #1 chk("frame", (n == 11) ? {1'b1, nb, b, 1'b0} : {2'b01, b, 1'b0}, v);
        chk("done_time", 11'h001 << (n - 1), t);
        chk("tx_flags", 11'h007, {8'h00, transmit_done_flag, transmit_collision_flag, irq});
        $display("tx test done");
    endtask : txc

    task automatic rxc(input ufm_pkg::ufm_mode_e m, input logic mp, input logic [9:0] f, input int n, input int bc,
                       input logic acc, input logic [5:0] c);
        @(posedge clk);
        mode <= m;
        multiproc_enable <= mp;
        repeat (4) @(posedge clk);
        peer.send(f, n, bc);
        repeat (4) @(posedge clk);
        #1 chk("rx_done", {10'h000, acc}, {10'h000, receive_done_flag});
        if (acc) chk("rx_data", {2'b00, f[8:0]}, {2'b00, received_ninth_bit, serial_data_buffer});
        @(posedge clk);
        clr(c);
        $display("rx test done");
    endtask : rxc

    // Synchronous mode: send a byte, then clock one in from the peer.
    task automatic syc(input logic [7:0] b, input logic [6:0] f);
        logic [7:0] v;
        logic [7:0] lo;
        logic [7:0] hi;
        int         i;
        @(posedge clk);
        clr(6'h20);
        mode <= ufm_pkg::MODE_SYNC;
        data_write_byte <= b;
        data_write <= 1'b1;
        @(posedge clk);
        data_write <= 1'b0;
        repeat (3) @(posedge clk);
        for (i = 0; i < 8; i++) begin
            #1 v[i] = serial_in_pin;
            lo[i] = serial_out_pin;
            repeat (6) @(posedge clk);
            #1 hi[i] = serial_out_pin;
            repeat (6) @(posedge clk);
        end
        #1 chk("sync_data", {3'b000, b}, {3'b000, v});
        chk("sync_clk_lo", 11'h000, {3'b000, lo});
        chk("sync_clk_hi", 11'h0ff, {3'b000, hi});
        chk("sync_ti", 11'h002, {9'h000, transmit_done_flag, serial_in_pin_out});
        @(posedge clk);
        clr(6'h10);
        peer.send({3'b000, f}, 7, 12);
        #1 chk("sync_rx", {3'b001, f, 1'b0}, {2'b00, receive_done_flag, serial_data_buffer});
        $display("sync test done");
    endtask : syc

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    initial begin
        {multiproc_enable, baud_double_bit, transmit_ninth_bit, data_write, data_read} = '0;
        {tx_baud_select_hi, tx_baud_select_lo, rx_baud_select_hi, data_write_byte} = '0;
        {clear_tx_done, clear_rx_done, clear_overrun, clear_framing, clear_collision} = '0;
        {sys_rst, irq_enable, receive_enable_bit, rx_baud_select_lo} = 4'hf;
        mode = ufm_pkg::MODE_FIXED9;
        slave_address_reg = 8'h35;
        slave_address_mask = 8'h0f;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk("idle", 11'h080, {3'b000, serial_out_pin, serial_in_pin_oe, irq, transmit_done_flag,
                receive_done_flag, receive_overrun_flag, framing_error_flag, transmit_collision_flag});
        txc(ufm_pkg::MODE_FIXED9, 1'b0, 2'b00, 11, 64, 8'ha5, 1'b1);
        txc(ufm_pkg::MODE_FIXED9, 1'b1, 2'b00, 11, 32, 8'h3c, 1'b0);
        txc(ufm_pkg::MODE_VAR9, 1'b0, 2'b00, 11, 64, 8'h96, 1'b1);
        txc(ufm_pkg::MODE_VAR9, 1'b1, 2'b00, 11, 32, 8'h01, 1'b0);
        txc(ufm_pkg::MODE_ASYNC8, 1'b0, 2'b01, 10, 32, 8'h80, 1'b0);
        @(posedge clk);
        irq_enable <= 1'b0;
        baud_double_bit <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("irq_off", 11'h000, {10'h000, irq});
        @(posedge clk);
        irq_enable <= 1'b1;
        rxc(ufm_pkg::MODE_FIXED9, 1'b0, 10'h25a, 10, 64, 1'b1, 6'h11);
        rxc(ufm_pkg::MODE_FIXED9, 1'b1, 10'h3f5, 10, 64, 1'b1, 6'h11);
        rxc(ufm_pkg::MODE_FIXED9, 1'b1, 10'h3ff, 10, 64, 1'b1, 6'h11);
        rxc(ufm_pkg::MODE_FIXED9, 1'b1, 10'h2f5, 10, 64, 1'b0, 6'h11);
        rxc(ufm_pkg::MODE_FIXED9, 1'b1, 10'h336, 10, 64, 1'b0, 6'h11);
        rxc(ufm_pkg::MODE_ASYNC8, 1'b1, 10'h03c, 9, 32, 1'b0, 6'h00);
        rxc(ufm_pkg::MODE_ASYNC8, 1'b0, 10'h1c3, 9, 32, 1'b1, 6'h10);
        rxc(ufm_pkg::MODE_ASYNC8, 1'b1, 10'h181, 9, 32, 1'b1, 6'h00);
        #1 chk("err_flags", 11'h007, {8'h00, receive_overrun_flag, framing_error_flag, transmit_done_flag});
        syc(8'h6c, 7'h5a);
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule : ufm_uart_test
`default_nettype wire
